// ===== cbs_pkg.sv
// Shared constants and types for the card-slot control block
package cbs_pkg;

    // ****
    // Clock and timing
    // ****
    localparam int SYS_CLK_PERIOD_PS = 8000;
    localparam int DET_STABLE_NS     = 1000;
    localparam int DET_STABLE_CYC    = (DET_STABLE_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
    localparam int DEVSEL_TO_CCLKS   = 5;
    localparam int SYNC_STAGES       = 2;

    // ****
    // Bus encodings
    // ****
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [7:0] LEN_ONE     = 8'h01;
    localparam logic [7:0] LEN_TWO     = 8'h02;

    // ****
    // Reset values
    // ****
    localparam logic PIN_IDLE_RST = 1'b1;
    localparam logic OE_RST       = 1'b0;

    // ****
    // Types
    // ****
    typedef enum logic [2:0]
    {
        INI_IDLE = 3'b000,
        INI_ADDR = 3'b001,
        INI_DATA = 3'b010,
        INI_TURN = 3'b011,
        INI_REL  = 3'b100
    } cbs_ini_st_t;

    typedef enum logic [1:0]
    {
        OWN_NONE = 2'b00,
        OWN_CARD = 2'b01,
        OWN_SELF = 2'b10
    } cbs_own_t;

    // Pins that arrive from the slot, synchronised as one group
    typedef struct packed
    {
        logic        cclk;
        logic        frame_n;
        logic        irdy_n;
        logic        trdy_n;
        logic        devsel_n;
        logic        lock_n;
        logic        req_n;
        logic        int_n;
        logic [1:0]  ccd_n;
        logic [1:0]  vs;
        logic        audio;
        logic        par;
        logic [3:0]  cbe_n;
        logic [31:0] ad;
    } cbs_lnk_in_t;

    // Initiator request from the bridge core
    typedef struct packed
    {
        logic       start;
        logic       lock;
        logic [7:0] len;
    } cbs_req_t;

endpackage

// ===== cbs_sync.sv
// Two-stage synchroniser for a group of slot pins
`timescale 1ns/1ps
module cbs_sync
    import cbs_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    // ****
    // Next values
    // ****
    always_comb
    begin
        meta_d = d;
        q_d    = meta_q;
    end

    // ****
    // Registers
    // ****
    // Idle-high reset so active-low pins read as inactive
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= '1;
            q      <= '1;
        end
        else
        begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end

endmodule

// ===== cbs_slot.sv
// Host-side slot control: framing, handshake, arbiter, parity, detect, audio
`timescale 1ns/1ps
module cbs_slot
    import cbs_pkg::*;
#(
    parameter int DEVSEL_TO  = DEVSEL_TO_CCLKS,
    parameter int DET_CYCLES = DET_STABLE_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        cclk,
    input  wire logic        frame_n_i,
    output logic             frame_n_o,
    output logic             frame_n_oe,
    input  wire logic        irdy_n_i,
    output logic             irdy_n_o,
    output logic             irdy_n_oe,
    input  wire logic        trdy_n_i,
    input  wire logic        devsel_n_i,
    input  wire logic        lock_n_i,
    output logic             lock_n_o,
    output logic             lock_n_oe,
    input  wire logic        perr_n_i,
    output logic             perr_n_o,
    output logic             perr_n_oe,
    input  wire logic        par_i,
    output logic             par_o,
    output logic             par_oe,
    input  wire logic [31:0] ad_i,
    input  wire logic [3:0]  cbe_n_i,
    input  wire logic        req_n_i,
    output logic             gnt_n_o,
    input  wire logic        int_n_i,
    input  wire logic [1:0]  ccd_n_i,
    input  wire logic [1:0]  vs_i,
    input  wire logic        audio_i,
    output logic             speaker_out,
    input  wire logic        audio_en,
    input  wire cbs_req_t    usr_req,
    output logic             usr_busy,
    output logic             usr_phase,
    output logic             usr_done,
    output logic             usr_abort,
    output logic             card_irq,
    output logic             card_present,
    output logic [3:0]       card_type,
    output logic             parity_err,
    output logic             lock_other
);

    // ****
    // Helpers
    // ****
    function automatic logic par_fn(input logic [31:0] ad, input logic [3:0] cbe);
        par_fn = ^{ad, cbe};
    endfunction

    // ****
    // Pin synchronisation and clock edge
    // ****
    cbs_lnk_in_t raw;
    cbs_lnk_in_t s;

    always_comb
    begin
        raw = '{cclk: cclk, frame_n: frame_n_i, irdy_n: irdy_n_i, trdy_n: trdy_n_i,
                devsel_n: devsel_n_i, lock_n: lock_n_i, req_n: req_n_i, int_n: int_n_i,
                ccd_n: ccd_n_i, vs: vs_i, audio: audio_i, par: par_i, cbe_n: cbe_n_i, ad: ad_i};
    end

    cbs_sync #(.W($bits(cbs_lnk_in_t))) u_sync
    (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .d       (raw),
        .q       (s)
    );

    logic cclk_q;
    logic ce;
    assign ce = s.cclk & ~cclk_q;

    // ****
    // Initiator sequencing
    // ****
    cbs_ini_st_t ist_q, ist_d;
    logic [7:0]  rem_q, rem_d;
    logic [7:0]  to_q, to_d;
    logic        claimed_q, claimed_d;
    logic        pend_q, pend_d;
    logic        plock_q, plock_d;
    logic        fr_q, fr_d, fr_oe_q, fr_oe_d;
    logic        ir_q, ir_d, ir_oe_q, ir_oe_d;
    logic        lk_q, lk_d, lk_oe_q, lk_oe_d;
    logic        po_q, po_d, po_oe_q, po_oe_d;
    logic        ph_q, ph_d, dn_q, dn_d, ab_q, ab_d;
    logic [7:0]  req_len_q, req_len_d;
    cbs_own_t    own_q;
    logic        both_rdy;

    // Both readies sampled together end a phase; otherwise a wait state
    assign both_rdy = ~s.irdy_n & ~s.trdy_n;

    always_comb
    begin
        ist_d = ist_q; rem_d = rem_q; to_d = to_q; claimed_d = claimed_q;
        pend_d = pend_q | usr_req.start;
        plock_d = plock_q; req_len_d = usr_req.start ? usr_req.len : req_len_q;
        fr_d = fr_q; fr_oe_d = fr_oe_q; ir_d = ir_q; ir_oe_d = ir_oe_q;
        lk_d = lk_q; lk_oe_d = lk_oe_q; po_d = po_q; po_oe_d = po_oe_q;
        ph_d = 1'b0; dn_d = 1'b0; ab_d = 1'b0;
        if (ce)
        begin
            // Parity follows the sampled bus one edge late while we own it
            po_d    = par_fn(s.ad, s.cbe_n);
            po_oe_d = (ist_q == INI_ADDR) || (ist_q == INI_DATA);
            case (ist_q)
                INI_IDLE:
                begin
                    if (pend_q && own_q == OWN_SELF && s.frame_n && s.irdy_n)
                    begin
                        fr_d = 1'b0; fr_oe_d = 1'b1;
                        ir_oe_d = 1'b1; ir_d = 1'b1;
                        rem_d = (req_len_q == 8'h00) ? LEN_ONE : req_len_q;
                        plock_d = usr_req.lock;
                        pend_d = usr_req.start;
                        ist_d = INI_ADDR;
                    end
                end
                INI_ADDR:
                begin
                    fr_d = (rem_q == LEN_ONE);
                    ir_d = 1'b0;
                    to_d = 8'h00; claimed_d = 1'b0;
                    if (plock_q)
                    begin
                        lk_d = 1'b0; lk_oe_d = 1'b1;
                    end
                    ist_d = INI_DATA;
                end
                INI_DATA:
                begin
                    if (!s.devsel_n)
                        claimed_d = 1'b1;
                    else if (!claimed_q)
                        to_d = 8'(to_q + 8'h01);
                    if (!claimed_q && s.devsel_n && to_q >= 8'(DEVSEL_TO - 1))
                    begin
                        fr_d = 1'b1; ir_d = 1'b1; ab_d = 1'b1;
                        ist_d = INI_TURN;
                    end
                    else if (both_rdy)
                    begin
                        ph_d = 1'b1;
                        rem_d = 8'(rem_q - 8'h01);
                        if (s.frame_n)
                        begin
                            ir_d = 1'b1; dn_d = 1'b1;
                            ist_d = INI_TURN;
                        end
                        else if (rem_q == LEN_TWO)
                            fr_d = 1'b1;
                    end
                end
                INI_TURN:
                begin
                    fr_oe_d = 1'b0; ir_oe_d = 1'b0;
                    if (!plock_q || !usr_req.lock)
                    begin
                        lk_d = 1'b1;
                    end
                    ist_d = INI_REL;
                end
                INI_REL:
                begin
                    if (lk_q)
                        lk_oe_d = 1'b0;
                    ist_d = INI_IDLE;
                end
                default:
                    ist_d = INI_IDLE;
            endcase
            // A held lock is released once the core drops it while idle
            if (ist_q == INI_IDLE && !lk_q && !usr_req.lock)
                lk_d = 1'b1;
            if (ist_q == INI_IDLE && lk_q && lk_oe_q)
                lk_oe_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ist_q <= INI_IDLE; rem_q <= 8'h00; to_q <= 8'h00; claimed_q <= 1'b0;
            pend_q <= 1'b0; plock_q <= 1'b0; req_len_q <= 8'h00;
            fr_q <= PIN_IDLE_RST; fr_oe_q <= OE_RST; ir_q <= PIN_IDLE_RST; ir_oe_q <= OE_RST;
            lk_q <= PIN_IDLE_RST; lk_oe_q <= OE_RST; po_q <= 1'b0; po_oe_q <= OE_RST;
            ph_q <= 1'b0; dn_q <= 1'b0; ab_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d; rem_q <= rem_d; to_q <= to_d; claimed_q <= claimed_d;
            pend_q <= pend_d; plock_q <= plock_d; req_len_q <= req_len_d;
            fr_q <= fr_d; fr_oe_q <= fr_oe_d; ir_q <= ir_d; ir_oe_q <= ir_oe_d;
            lk_q <= lk_d; lk_oe_q <= lk_oe_d; po_q <= po_d; po_oe_q <= po_oe_d;
            ph_q <= ph_d; dn_q <= dn_d; ab_q <= ab_d;
        end
    end

    // ****
    // Slot arbiter
    // ****
    cbs_own_t own_d;
    logic     gnt_q, gnt_d;
    logic     bus_idle;

    // Idle means no frame and no ready: the running transaction is over
    assign bus_idle = s.frame_n & s.irdy_n & (ist_q == INI_IDLE);

    always_comb
    begin
        own_d = own_q;
        gnt_d = gnt_q;
        if (ce)
        begin
            case (own_q)
                OWN_NONE:
                begin
                    // Own pending work wins ties so the bridge cannot starve
                    if (pend_q && bus_idle)
                        own_d = OWN_SELF;
                    else if (!s.req_n && bus_idle)
                    begin
                        own_d = OWN_CARD;
                        gnt_d = 1'b0;
                    end
                end
                OWN_CARD:
                begin
                    if (s.req_n || pend_q)
                        gnt_d = 1'b1;
                    if (gnt_q && bus_idle)
                        own_d = OWN_NONE;
                end
                OWN_SELF:
                begin
                    if (ist_q == INI_IDLE && !pend_q && lk_q)
                        own_d = OWN_NONE;
                end
                default:
                    own_d = OWN_NONE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            own_q <= OWN_NONE;
            gnt_q <= PIN_IDLE_RST;
        end
        else
        begin
            own_q <= own_d;
            gnt_q <= gnt_d;
        end
    end

    // ****
    // Target parity check
    // ****
    logic frp_q, frp_d, spc_q, spc_d;
    logic chk_q, chk_d, exp_q, exp_d;
    logic bad_q, bad_d, pe_q, pe_d, pe_oe_q, pe_oe_d, pev_q, pev_d;

    always_comb
    begin
        frp_d = frp_q; spc_d = spc_q; chk_d = chk_q; exp_d = exp_q;
        bad_d = bad_q; pe_d = pe_q; pe_oe_d = pe_oe_q; pev_d = 1'b0;
        if (ce)
        begin
            frp_d = s.frame_n;
            if (frp_q && !s.frame_n)
                spc_d = (s.cbe_n == CMD_SPECIAL);
            // Edge k: data, edge k+1: parity, edge k+2: error drive
            chk_d = (own_q == OWN_CARD) && both_rdy && !spc_q;
            exp_d = par_fn(s.ad, s.cbe_n);
            bad_d = chk_q && (s.par != exp_q);
            pe_oe_d = bad_q | (pe_oe_q & ~pe_q);
            pe_d = ~bad_q;
            pev_d = bad_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            frp_q <= PIN_IDLE_RST; spc_q <= 1'b0; chk_q <= 1'b0; exp_q <= 1'b0;
            bad_q <= 1'b0; pe_q <= PIN_IDLE_RST; pe_oe_q <= OE_RST; pev_q <= 1'b0;
        end
        else
        begin
            frp_q <= frp_d; spc_q <= spc_d; chk_q <= chk_d; exp_q <= exp_d;
            bad_q <= bad_d; pe_q <= pe_d; pe_oe_q <= pe_oe_d; pev_q <= pev_d;
        end
    end

    // ****
    // Card detect, interrupt, audio, lock watch
    // ****
    logic [15:0] det_q, det_d;
    logic        pres_q, pres_d;
    logic [3:0]  type_q, type_d;
    logic        spk_q, spk_d, irq_q, irq_d, lko_q, lko_d;

    always_comb
    begin
        det_d = det_q; pres_d = pres_q; type_d = type_q;
        // Both detects low and stable means fully seated
        if (s.ccd_n != 2'b00)
        begin
            det_d = 16'h0000;
            pres_d = 1'b0;
        end
        else if (det_q < 16'(DET_CYCLES))
            det_d = 16'(det_q + 16'h0001);
        else if (!pres_q)
        begin
            pres_d = 1'b1;
            type_d = {s.vs, s.ccd_n};
        end
        spk_d = audio_en & s.audio;
        irq_d = ~s.int_n;
        lko_d = ~s.lock_n & ~lk_oe_q;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            det_q <= 16'h0000; pres_q <= 1'b0; type_q <= 4'h0;
            spk_q <= 1'b0; irq_q <= 1'b0; lko_q <= 1'b0; cclk_q <= PIN_IDLE_RST;
        end
        else
        begin
            det_q <= det_d; pres_q <= pres_d; type_q <= type_d;
            spk_q <= spk_d; irq_q <= irq_d; lko_q <= lko_d; cclk_q <= s.cclk;
        end
    end

    // ****
    // Outputs
    // ****
    assign frame_n_o = fr_q;      assign frame_n_oe = fr_oe_q;
    assign irdy_n_o  = ir_q;      assign irdy_n_oe  = ir_oe_q;
    assign lock_n_o  = lk_q;      assign lock_n_oe  = lk_oe_q;
    assign perr_n_o  = pe_q;      assign perr_n_oe  = pe_oe_q;
    assign par_o     = po_q;      assign par_oe     = po_oe_q;
    assign gnt_n_o   = gnt_q;     assign speaker_out = spk_q;
    assign usr_busy  = pend_q;    assign usr_phase  = ph_q;
    assign usr_done  = dn_q;      assign usr_abort  = ab_q;
    assign card_irq  = irq_q;     assign card_present = pres_q;
    assign card_type = type_q;    assign parity_err = pev_q;
    assign lock_other = lko_q;

endmodule

// ===== cbs_slot_chk.sv
// Port-level assertions for the slot control block
`timescale 1ns/1ps
module cbs_slot_chk
    import cbs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic frame_n_i,
    input wire logic frame_n_o,
    input wire logic frame_n_oe,
    input wire logic irdy_n_o,
    input wire logic irdy_n_oe,
    input wire logic devsel_n_i,
    input wire logic perr_n_o,
    input wire logic perr_n_oe,
    input wire logic gnt_n_o,
    input wire logic int_n_i,
    input wire logic audio_i,
    input wire logic audio_en,
    input wire logic speaker_out,
    input wire logic usr_phase,
    input wire logic usr_done,
    input wire logic usr_abort,
    input wire logic card_irq
);
    // ****
    // Checks
    // ****
    logic [2:0] up_d;
    logic [2:0] up_q;
    // Delayed compares must not look back into reset
    always_comb up_d = (up_q == 3'h4) ? up_q : up_q + 3'h1;
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            up_q <= 3'h0;
        else
            up_q <= up_d;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    audio_pass_a:
        assert property (up_q == 3'h4 |-> speaker_out == ($past(audio_en) && $past(audio_i, 3)))
            else $error("speaker out");
    irq_follow_a:
        assert property (up_q == 3'h4 |-> card_irq == !$past(int_n_i, 3)) else $error("card irq");
    grant_idle_a:
        assert property ($fell(gnt_n_o) |-> frame_n_i) else $error("grant mid transfer");
    one_owner_a:
        assert property (!gnt_n_o |-> !(frame_n_oe && !frame_n_o)) else $error("two owners");
    abort_nosel_a:
        assert property (usr_abort |-> devsel_n_i && !usr_done) else $error("abort while claimed");
    frame_release_a:
        assert property ($fell(frame_n_oe) |-> $past(frame_n_o)) else $error("frame dropped low");
    last_phase_a:
        assert property ($rose(frame_n_o) && frame_n_oe && !usr_abort |-> !irdy_n_o) else $error("frame end");
    done_phase_a:
        assert property (usr_done |-> usr_phase) else $error("done without phase");
    perr_hold_a:
        assert property ($fell(perr_n_o) |-> perr_n_oe ##1 (perr_n_oe && !perr_n_o)[*8]) else $error("perr pulse");
    oe_pair_a:
        assert property (frame_n_oe == irdy_n_oe) else $error("oe pair");
endmodule
bind cbs_slot cbs_slot_chk u_chk
(
    .sys_clk(sys_clk), .rstn(rstn), .frame_n_i(frame_n_i), .frame_n_o(frame_n_o), .frame_n_oe(frame_n_oe),
    .irdy_n_o(irdy_n_o), .irdy_n_oe(irdy_n_oe), .devsel_n_i(devsel_n_i), .perr_n_o(perr_n_o),
    .perr_n_oe(perr_n_oe), .gnt_n_o(gnt_n_o), .int_n_i(int_n_i), .audio_i(audio_i), .audio_en(audio_en),
    .speaker_out(speaker_out), .usr_phase(usr_phase), .usr_done(usr_done), .usr_abort(usr_abort),
    .card_irq(card_irq)
);

// ===== cbs_card.sv
// Behavioural card in the slot: target answers and one-phase own transfers
`timescale 1ns/1ps
module cbs_card
    import cbs_pkg::*;
(
    input  wire logic        cclk,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic        gnt_n,
    input  wire logic        resp_en,
    input  wire logic [1:0]  waits,
    input  wire logic        go,
    input  wire logic        bad_par,
    input  wire logic [3:0]  cmd,
    input  wire logic [31:0] fill,
    output wire logic        fr_o,
    output wire logic        fr_oe,
    output wire logic        ir_o,
    output wire logic        ir_oe,
    output wire logic        trdy_n,
    output wire logic        sel_n,
    output wire logic        req_n,
    output wire logic        par,
    output wire logic [31:0] ad,
    output wire logic [3:0]  cbe,
    output wire logic        busy
);
    // ****
    // Card
    // ****
    logic [2:0]  st_q = 3'h0;
    logic [1:0]  wc_q = 2'h0;
    logic [31:0] a_q  = 32'h0;
    logic [3:0]  c_q  = 4'h0;
    logic        tg_q = 1'b0, sel_q = 1'b1, rdy_q = 1'b1, fr_q = 1'b1, fo_q = 1'b0;
    logic        ir_q = 1'b1, io_q = 1'b0, rq_q = 1'b1, pr_q = 1'b0, po_q = 1'b0, tx_q = 1'b1;
    // Clock-to-out of 20 ns keeps changes clear of the sampling edge
    assign #20 {fr_o, fr_oe, ir_o, ir_oe, req_n, par, ad, cbe} = {fr_q, fo_q, ir_q, io_q, rq_q, pr_q, a_q, c_q};
    assign #20 trdy_n = (st_q >= 3'h2) ? tx_q : rdy_q;
    assign #20 sel_n = sel_q;
    assign busy = (st_q != 3'h0);
    always @(posedge cclk)
    begin
        if (tg_q && !irdy_n && !rdy_q)
        begin
            rdy_q <= 1'b1;
            wc_q  <= waits;
            tg_q  <= !frame_n;
            sel_q <= frame_n;
        end
        else if (tg_q && wc_q != 2'h0)
            wc_q <= wc_q - 2'h1;
        else if (tg_q)
            rdy_q <= 1'b0;
        else if (st_q < 3'h2 && !frame_n && resp_en)
        begin
            tg_q  <= 1'b1;
            sel_q <= 1'b0;
            wc_q  <= waits;
        end
        // Undriven parity line shows a moving pattern, not its last value
        if (!po_q)
            pr_q <= ~pr_q;
        if (st_q <= 3'h2)
            a_q <= fill;
        case (st_q)
            3'h0:
            begin
                st_q <= go ? 3'h1 : 3'h0;
                rq_q <= !go;
                c_q  <= fill[7:4];
            end
            3'h1:
            begin
                c_q <= (!gnt_n && frame_n && irdy_n) ? cmd : fill[7:4];
                if (!gnt_n && frame_n && irdy_n)
                begin
                    {fr_q, fo_q, io_q} <= 3'b011;
                    st_q <= 3'h2;
                end
            end
            3'h2:
            begin
                {fr_q, ir_q, tx_q, po_q} <= 4'b1001;
                pr_q <= ^{a_q, c_q};
                c_q  <= 4'h0;
                st_q <= 3'h3;
            end
            3'h3:
            begin
                {ir_q, tx_q, fo_q, rq_q} <= 4'b1101;
                pr_q <= ^{a_q, c_q} ^ bad_par;
                st_q <= 3'h4;
            end
            default:
            begin
                {io_q, po_q} <= 2'b00;
                st_q <= 3'h0;
            end
        endcase
    end
endmodule

// ===== tb_top.sv
// Self-checking bench for the slot control block
`timescale 1ns/1ps
module tb_top;
    import cbs_pkg::*;
    // ****
    // Bench
    // ****
    logic        sys_clk = 1'b0, rstn = 1'b0, cclk = 1'b0, int_n = 1'b1, audio = 1'b0, audio_en = 1'b0;
    logic [1:0]  ccd_n = 2'h3, vs = 2'h0, waits = 2'h0;
    logic        resp_en = 1'b1, go = 1'b0, bad_par = 1'b0, p_prev = 1'b0, p_exp = 1'b0, ext_lk = 1'b1;
    logic [3:0]  cmd = 4'h7, c_cbe, card_type;
    logic [31:0] fill = 32'h0, c_ad;
    logic [15:0] rnd = 16'hAD1A;
    cbs_req_t    usr_req = '0;
    logic        frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, lock_n_o, lock_n_oe, perr_n_o, perr_n_oe;
    logic        par_o, par_oe, gnt_n_o, speaker_out, usr_busy, usr_phase, usr_done, usr_abort;
    logic        card_irq, card_present, parity_err, lock_other, c_fr, c_fo, c_ir, c_io, c_trdy, c_sel;
    logic        c_req, c_par, c_busy;
    int          n_mismatch = 0, cmp_count = 0, n_ph = 0, n_dn = 0, n_ab = 0, n_pe = 0, lk_s = 0, gn_s = 0;
    // Control lines have pull-ups; ext_lk stands for another lock holder
    wire logic   frame_w = frame_n_oe ? frame_n_o : (c_fo ? c_fr : 1'b1);
    wire logic   irdy_w  = irdy_n_oe ? irdy_n_o : (c_io ? c_ir : 1'b1);
    wire logic   lock_w  = lock_n_oe ? lock_n_o : ext_lk;
    wire logic   perr_w  = perr_n_oe ? perr_n_o : 1'b1;
    wire logic   par_w   = par_oe ? par_o : c_par;
    always #4 sys_clk = ~sys_clk;
    always #62.5 cclk = ~cclk;
    cbs_slot #(.DET_CYCLES(4)) uut
    (
        .sys_clk(sys_clk), .rstn(rstn), .cclk(cclk), .frame_n_i(frame_w), .frame_n_o(frame_n_o),
        .frame_n_oe(frame_n_oe), .irdy_n_i(irdy_w), .irdy_n_o(irdy_n_o), .irdy_n_oe(irdy_n_oe),
        .trdy_n_i(c_trdy), .devsel_n_i(c_sel), .lock_n_i(lock_w), .lock_n_o(lock_n_o), .lock_n_oe(lock_n_oe),
        .perr_n_i(perr_w), .perr_n_o(perr_n_o), .perr_n_oe(perr_n_oe), .par_i(par_w), .par_o(par_o),
        .par_oe(par_oe), .ad_i(c_ad), .cbe_n_i(c_cbe), .req_n_i(c_req), .gnt_n_o(gnt_n_o), .int_n_i(int_n),
        .ccd_n_i(ccd_n), .vs_i(vs), .audio_i(audio), .speaker_out(speaker_out), .audio_en(audio_en),
        .usr_req(usr_req), .usr_busy(usr_busy), .usr_phase(usr_phase), .usr_done(usr_done),
        .usr_abort(usr_abort), .card_irq(card_irq), .card_present(card_present), .card_type(card_type),
        .parity_err(parity_err), .lock_other(lock_other)
    );
    cbs_card card
    (
        .cclk(cclk), .frame_n(frame_w), .irdy_n(irdy_w), .gnt_n(gnt_n_o), .resp_en(resp_en), .waits(waits),
        .go(go), .bad_par(bad_par), .cmd(cmd), .fill(fill), .fr_o(c_fr), .fr_oe(c_fo), .ir_o(c_ir),
        .ir_oe(c_io), .trdy_n(c_trdy), .sel_n(c_sel), .req_n(c_req), .par(c_par), .ad(c_ad), .cbe(c_cbe),
        .busy(c_busy)
    );
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic ini_run(input logic [7:0] len, input logic [1:0] w, input logic lk, input logic rsp);
        resp_en = rsp;
        waits   = w;
        {n_ph, n_dn, n_ab, lk_s} = '0;
        usr_req = '{start: 1'b1, lock: lk, len: len};
        @(negedge sys_clk);
        usr_req.start = 1'b0;
        check("busy", 1, usr_busy);
        for (int t = 0; t < 3000 && n_dn + n_ab == 0; t++)
            @(negedge sys_clk);
        usr_req.lock = 1'b0;
        repeat (80) @(negedge sys_clk);
        check("phases", rsp ? ((len == 8'h0) ? 1 : len) : 0, n_ph);
        check("done", rsp, n_dn);
        check("abort", !rsp, n_ab);
        check("lock", lk, lk_s);
    endtask
    always @(posedge sys_clk)
    begin
        n_ph += (usr_phase === 1'b1);
        n_dn += (usr_done === 1'b1);
        n_ab += (usr_abort === 1'b1);
        n_pe += (parity_err === 1'b1);
        lk_s |= (lock_n_oe === 1'b1 && lock_n_o === 1'b0);
        gn_s |= (gnt_n_o === 1'b0);
    end
    always @(posedge cclk)
        p_exp = ^{c_ad, c_cbe};
    always @(negedge cclk)
    begin
        if (par_oe === 1'b1 && p_prev)
            check("par_o", p_exp, par_o);
        p_prev = (par_oe === 1'b1);
        rnd    = lfsr(rnd);
        fill   = {rnd, ~rnd};
    end
    initial
    begin
        // About 3k cycles are needed; 20k means a hang
        #160000;
        n_mismatch++;
        conclude();
    end
    initial
    begin
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            ccd_n = 2'h3;
            for (int t = 0; t < 200 && card_present !== 1'b0; t++)
                @(negedge sys_clk);
            check("card_present", 0, card_present);
            vs    = 2'(i);
            ccd_n = 2'h0;
            for (int t = 0; t < 200 && card_present !== 1'b1; t++)
                @(negedge sys_clk);
            check("card_type", {1'b1, 2'(i), 2'h0}, {card_present, card_type});
        end
        $display("detect test done");
        for (int i = 0; i < 200; i++)
        begin
            rnd = lfsr(rnd);
            {audio, audio_en, int_n} = rnd[2:0];
            @(negedge sys_clk);
        end
        {audio, audio_en, int_n, ext_lk} = 4'b1100;
        repeat (6) @(negedge sys_clk);
        check("speaker_out", 1, speaker_out);
        check("card_irq", 1, card_irq);
        check("lock_other", 1, lock_other);
        {audio_en, int_n, ext_lk} = 3'b011;
        repeat (6) @(negedge sys_clk);
        check("speaker_out", 0, speaker_out);
        check("card_irq", 0, card_irq);
        check("lock_other", 0, lock_other);
        $display("audio and interrupt test done");
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            ini_run((i < 2) ? 8'(i) : 8'(rnd[1:0]) + 8'h1, 2'(rnd[3:2] % 3), rnd[4], 1'b1);
        end
        ini_run(8'h1, 2'h0, 1'b0, 1'b0);
        resp_en = 1'b1;
        $display("initiator test done");
        for (int i = 0; i < 4; i++)
        begin
            rnd     = lfsr(rnd);
            bad_par = (i != 0);
            cmd     = (i == 2) ? CMD_SPECIAL : {1'b1, rnd[2:0]};
            n_pe    = 0;
            gn_s    = 0;
            go      = 1'b1;
            for (int t = 0; t < 400 && c_busy !== 1'b1; t++)
                @(negedge sys_clk);
            go = 1'b0;
            for (int t = 0; t < 400 && c_busy !== 1'b0; t++)
                @(negedge sys_clk);
            repeat (80) @(negedge sys_clk);
            check("grant", 1, gn_s);
            check("parity_err", (i == 1 || i == 3), n_pe);
        end
        $display("card initiator test done");
        conclude();
    end
endmodule
